// [rtl/pcc_pkg.sv]
// ==========================================================
// Clock configuration constants and types
package pcc_pkg;

  // ==========================================================
  // Field widths
  localparam int DIV_W = 5;
  localparam int MULT_W = 8;
  localparam int FREQ_W = 32;

  // ==========================================================
  // Reset values of the configuration fields
  localparam logic [DIV_W-1:0] DIV_RST = 5'h00;
  localparam logic [MULT_W-1:0] MULT_RST = 8'h00;
  localparam logic RNG_RST = 1'b0;

  // ==========================================================
  // Frequency windows, all in kHz
  localparam logic [FREQ_W-1:0] DIVIDED_MIN_KHZ = 32'd10000;
  localparam logic [FREQ_W-1:0] DIVIDED_MAX_KHZ = 32'd25000;
  localparam logic [FREQ_W-1:0] LOOP_MIN_KHZ = 32'd266000;
  localparam logic [FREQ_W-1:0] LOOP_MAX_KHZ = 32'd532000;
  localparam logic [FREQ_W-1:0] REF_MIN_KHZ = 32'd10000;
  localparam logic [FREQ_W-1:0] REF_MAX_KHZ = 32'd100000;
  localparam logic [FREQ_W-1:0] CORE_MAX_KHZ = 32'd266000;
  localparam logic [FREQ_W-1:0] CLKOUT_MAX_KHZ = 32'd67000;
  localparam logic [FREQ_W-1:0] BUS_MAX_KHZ = 32'd133000;

  // Largest legal divider field value, divide by ten
  localparam logic [DIV_W-1:0] DIV_MAX_FIELD = 5'h09;

  // ==========================================================
  // Core clock source codes
  typedef enum logic [1:0] {
    PCC_SRC_REF = 2'h0,
    PCC_SRC_VCO_HALF = 2'h1,
    PCC_SRC_ALT_REF = 2'h2,
    PCC_SRC_VCO = 2'h3
  } pcc_src_t;

  localparam pcc_src_t SRC_RST = PCC_SRC_REF;

  // ==========================================================
  // Clock control register image
  typedef struct packed {
    logic [DIV_W-1:0] pll_input_divider;
    logic [MULT_W-1:0] pll_loop_multiplier;
    logic vco_range_select;
    pcc_src_t core_clock_source_select;
  } pcc_cfg_t;

  // Derived frequencies
  typedef struct packed {
    logic [FREQ_W-1:0] divided_khz;
    logic [FREQ_W-1:0] loop_khz;
    logic [FREQ_W-1:0] vco_khz;
    logic [FREQ_W-1:0] core_khz;
  } pcc_freq_t;

  // Configuration check flags
  typedef struct packed {
    logic ref_out_of_range;
    logic divider_too_large;
    logic divided_out_of_range;
    logic loop_out_of_range;
    logic core_too_fast;
    logic reserved_source;
  } pcc_err_t;

endpackage

// [rtl/pcc_clock_config.sv]
`timescale 1ns/10ps
// What this block does
// RULE1: Software sets the divider, multiplier, range bit and source select as one clock control image.
// RULE2: The reference frequency is divided by the divider field plus one before the multiplier.
// RULE3: The divided frequency times the multiplier field plus one gives the loop frequency.
// RULE4: Range bit one passes the loop frequency to the oscillator, range bit zero halves it.
// RULE5: The source select picks the reference, the oscillator or half the oscillator as core clock.
// RULE6: Software keeps the divided frequency within 10 to 25 MHz.
// RULE7: Software keeps the loop frequency within 266 to 532 MHz.
// RULE8: Divider values 0x00 to 0x09 divide by 1 to 10 and each bounds the usable reference range.
// RULE9: The reference lies within 10 to 100 MHz so the divider never exceeds divide by ten.
// RULE10: Configuration keeps core at most 266 MHz, clock output 67 MHz, memory and bus 133 MHz. The block flags only the core limit.
// RULE11: Code 11 range 0 and code 01 range 1 divide loop by 2, 01 range 0 by 4, 11 range 1 is reserved.
module pcc_clock_config
  import pcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Reference clock frequency, kHz
  input wire logic [FREQ_W-1:0] ref_freq_khz,
  // Clock control register write
  input wire logic cfg_load,
  input wire pcc_cfg_t cfg_in,
  // Clock control register readback
  output pcc_cfg_t clock_control_register,
  // Derived frequencies
  output pcc_freq_t freq_q,
  // Configuration checks
  output pcc_err_t err_q
);

  // ==========================================================
  // Clock control register
  pcc_cfg_t cfg_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= '{DIV_RST, MULT_RST, RNG_RST, SRC_RST};
    end else if (cfg_load) begin
      cfg_q <= cfg_in; // see RULE1
    end
  end

  assign clock_control_register = cfg_q;

  // ==========================================================
  // Frequency arithmetic
  function automatic logic [FREQ_W-1:0] half(input logic [FREQ_W-1:0] f);
    half = f >> 1;
  endfunction

  function automatic logic out_of(input logic [FREQ_W-1:0] f, input logic [FREQ_W-1:0] lo,
                                  input logic [FREQ_W-1:0] hi);
    out_of = (f < lo) || (f > hi);
  endfunction

  function automatic logic [FREQ_W-1:0] factor_of(input logic [FREQ_W-1:0] field);
    factor_of = field + 32'h1;
  endfunction

  // ==========================================================
  // Input divider stage
  logic [FREQ_W-1:0] div_factor;
  logic [FREQ_W-1:0] divided_khz;

  // Integer kHz arithmetic; fractions of a kHz are dropped, fine for range checks
  always_comb begin
    div_factor = factor_of(FREQ_W'(cfg_q.pll_input_divider));
    divided_khz = ref_freq_khz / div_factor; // see RULE2
  end

  // ==========================================================
  // Loop multiplier stage
  logic [FREQ_W-1:0] mult_factor;
  logic [2*FREQ_W-1:0] loop_wide;
  logic [FREQ_W-1:0] loop_khz;

  // Saturate so an overflow never wraps into a small, legal looking loop frequency
  always_comb begin
    mult_factor = factor_of(FREQ_W'(cfg_q.pll_loop_multiplier));
    loop_wide = {{FREQ_W{1'b0}}, divided_khz} * {{FREQ_W{1'b0}}, mult_factor}; // see RULE3
    if (loop_wide[2*FREQ_W-1:FREQ_W] != '0) begin
      loop_khz = '1;
    end else begin
      loop_khz = loop_wide[FREQ_W-1:0];
    end
  end

  // ==========================================================
  // Oscillator range stage
  logic [FREQ_W-1:0] vco_khz;

  always_comb begin
    if (cfg_q.vco_range_select) begin
      vco_khz = loop_khz; // see RULE4
    end else begin
      vco_khz = half(loop_khz); // see RULE4
    end
  end

  // ==========================================================
  // Core clock source selection
  logic [FREQ_W-1:0] core_khz;
  logic reserved_src;

  always_comb begin
    reserved_src = (cfg_q.core_clock_source_select == PCC_SRC_VCO) && cfg_q.vco_range_select; // see RULE11
    unique case (cfg_q.core_clock_source_select)
      PCC_SRC_VCO: begin
        // Reserved pairing reports no clock rather than an undefined one
        if (cfg_q.vco_range_select) begin
          core_khz = '0; // see RULE11
        end else begin
          core_khz = vco_khz; // see RULE11
        end
      end
      PCC_SRC_VCO_HALF: begin
        core_khz = half(vco_khz); // see RULE5
      end
      PCC_SRC_REF, PCC_SRC_ALT_REF: begin
        core_khz = ref_freq_khz; // see RULE5
      end
    endcase
  end

  // ==========================================================
  // Configuration checks
  // Flags only report; the block still computes whatever software wrote
  logic ref_bad;
  logic div_bad;
  logic divided_bad;
  logic loop_bad;
  logic core_bad;

  assign ref_bad = out_of(ref_freq_khz, REF_MIN_KHZ, REF_MAX_KHZ); // see RULE9
  assign div_bad = cfg_q.pll_input_divider > DIV_MAX_FIELD; // see RULE8
  assign divided_bad = out_of(divided_khz, DIVIDED_MIN_KHZ, DIVIDED_MAX_KHZ); // see RULE6
  assign loop_bad = out_of(loop_khz, LOOP_MIN_KHZ, LOOP_MAX_KHZ); // see RULE7
  assign core_bad = core_khz > CORE_MAX_KHZ; // see RULE10

  // ==========================================================
  // Derived frequency registers
  logic [FREQ_W-1:0] divided_q;
  logic [FREQ_W-1:0] loop_q;
  logic [FREQ_W-1:0] vco_q;
  logic [FREQ_W-1:0] core_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      divided_q <= '0;
    end else begin
      divided_q <= divided_khz;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loop_q <= '0;
    end else begin
      loop_q <= loop_khz;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vco_q <= '0;
    end else begin
      vco_q <= vco_khz;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_q <= '0;
    end else begin
      core_q <= core_khz;
    end
  end

  assign freq_q = '{divided_q, loop_q, vco_q, core_q};

  // ==========================================================
  // Check flag registers
  logic ref_bad_q;
  logic div_bad_q;
  logic divided_bad_q;
  logic loop_bad_q;
  logic core_bad_q;
  logic reserved_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ref_bad_q <= 1'b0;
    end else begin
      ref_bad_q <= ref_bad;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_bad_q <= 1'b0;
    end else begin
      div_bad_q <= div_bad;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      divided_bad_q <= 1'b0;
    end else begin
      divided_bad_q <= divided_bad;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loop_bad_q <= 1'b0;
    end else begin
      loop_bad_q <= loop_bad;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_bad_q <= 1'b0;
    end else begin
      core_bad_q <= core_bad;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reserved_q <= 1'b0;
    end else begin
      reserved_q <= reserved_src;
    end
  end

  assign err_q = '{ref_bad_q, div_bad_q, divided_bad_q, loop_bad_q, core_bad_q, reserved_q};

endmodule

// [tb/pcc_clock_config_props.sv]
`timescale 1ns/10ps
module pcc_clock_config_props
  import pcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched ports
  input wire logic [FREQ_W-1:0] ref_freq_khz,
  input wire logic cfg_load,
  input wire pcc_cfg_t cfg_in,
  input wire pcc_cfg_t clock_control_register,
  input wire pcc_freq_t freq_q,
  input wire pcc_err_t err_q
);
  // ========
  // Inputs of the edge that made freq_q
  pcc_cfg_t img_q;
  logic [FREQ_W-1:0] ref_q;
  logic live_q;
  always_ff @(posedge clk) begin
    img_q <= clock_control_register;
    ref_q <= ref_freq_khz;
    live_q <= !srst;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_load;
    cfg_load ##1 !srst;
  endsequence
  property p_load;
    s_load |-> clock_control_register == $past(cfg_in);
  endproperty
  a_load: assert property (p_load) else $error("image not loaded");
  property p_div;
    live_q |-> freq_q.divided_khz == ref_q / (img_q.pll_input_divider + 32'h1);
  endproperty
  a_div: assert property (p_div) else $error("divided wrong");
  // Saturated products are left out
  property p_loop;
    live_q && freq_q.loop_khz != 32'hffffffff
      |-> freq_q.loop_khz == freq_q.divided_khz * (img_q.pll_loop_multiplier + 32'h1);
  endproperty
  a_loop: assert property (p_loop) else $error("loop wrong");
  property p_vco;
    live_q |-> freq_q.vco_khz == (img_q.vco_range_select ? freq_q.loop_khz : freq_q.loop_khz >> 1);
  endproperty
  a_vco: assert property (p_vco) else $error("vco wrong");
  property p_ref;
    live_q && !img_q.core_clock_source_select[0] |-> freq_q.core_khz == ref_q;
  endproperty
  a_ref: assert property (p_ref) else $error("core not ref");
  property p_half;
    live_q && img_q.core_clock_source_select == PCC_SRC_VCO_HALF |-> freq_q.core_khz == freq_q.vco_khz >> 1;
  endproperty
  a_half: assert property (p_half) else $error("core not half");
  property p_rsv;
    live_q |-> err_q.reserved_source == (img_q.core_clock_source_select == PCC_SRC_VCO && img_q.vco_range_select);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  property p_src_vco;
    live_q && img_q.core_clock_source_select == PCC_SRC_VCO
      |-> freq_q.core_khz == (img_q.vco_range_select ? 32'h0 : freq_q.vco_khz);
  endproperty
  a_src_vco: assert property (p_src_vco) else $error("core not vco");
  property p_fast;
    live_q |-> err_q.core_too_fast == (freq_q.core_khz > CORE_MAX_KHZ);
  endproperty
  a_fast: assert property (p_fast) else $error("core limit flag wrong");
  property p_dvbig;
    live_q |-> err_q.divider_too_large == (img_q.pll_input_divider > DIV_MAX_FIELD);
  endproperty
  a_dvbig: assert property (p_dvbig) else $error("divider flag wrong");
endmodule
bind pcc_clock_config pcc_clock_config_props u_pcc_clock_config_props(.clk(clk), .srst(srst),
  .ref_freq_khz(ref_freq_khz), .cfg_load(cfg_load), .cfg_in(cfg_in),
  .clock_control_register(clock_control_register), .freq_q(freq_q), .err_q(err_q));

// [tb/pcc_sw_model.sv]
`timescale 1ns/10ps
module pcc_sw_model
  import pcc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Toward the block
  output logic [FREQ_W-1:0] ref_freq_khz,
  output logic cfg_load,
  output pcc_cfg_t cfg_in
);
  // ========
  // Whole image in one strobe, then garbage on the idle bus
  initial begin
    ref_freq_khz = 32'h000186a0;
    cfg_load = 1'b0;
    cfg_in = '0;
  end
  task automatic put(input logic [FREQ_W-1:0] r, input pcc_cfg_t c);
    @(negedge clk);
    ref_freq_khz = r;
    cfg_load = 1'b1;
    cfg_in = c;
    @(negedge clk);
    cfg_load = 1'b0;
    cfg_in = ~c;
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); \
  end \
end
module tb_top;
  import pcc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [FREQ_W-1:0] ref_freq_khz;
  logic cfg_load;
  pcc_cfg_t cfg_in, ccr;
  pcc_freq_t freq_q;
  pcc_err_t err_q;
  int n_errors = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  pcc_sw_model u_pcc_sw_model(.clk(clk), .ref_freq_khz(ref_freq_khz), .cfg_load(cfg_load), .cfg_in(cfg_in));
  pcc_clock_config u_pcc_clock_config(.clk(clk), .srst(srst), .ref_freq_khz(ref_freq_khz), .cfg_load(cfg_load),
    .cfg_in(cfg_in), .clock_control_register(ccr), .freq_q(freq_q), .err_q(err_q));
  // ========
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run(input logic [FREQ_W-1:0] r, input pcc_cfg_t c);
    logic [FREQ_W-1:0] d;
    logic [FREQ_W-1:0] l;
    logic [FREQ_W-1:0] o;
    logic [FREQ_W-1:0] v;
    logic rsv;
    rsv = c.core_clock_source_select == PCC_SRC_VCO && c.vco_range_select;
    d = r / (c.pll_input_divider + 32'h1);
    l = d * (c.pll_loop_multiplier + 32'h1);
    o = c.vco_range_select ? l : l >> 1;
    v = o;
    if (c.core_clock_source_select == PCC_SRC_VCO_HALF) v = v >> 1;
    if (rsv) v = '0;
    if (!c.core_clock_source_select[0]) v = r;
    u_pcc_sw_model.put(r, c);
    repeat (2) @(negedge clk);
    `CHK(ccr, c)
    `CHK(freq_q.divided_khz, d)
    `CHK(freq_q.loop_khz, l)
    `CHK(freq_q.vco_khz, o)
    `CHK(freq_q.core_khz, v)
    `CHK(err_q.reserved_source, rsv)
    `CHK(err_q.divider_too_large, c.pll_input_divider > DIV_MAX_FIELD)
    `CHK(err_q.ref_out_of_range, r < REF_MIN_KHZ || r > REF_MAX_KHZ)
    `CHK(err_q.divided_out_of_range, d < DIVIDED_MIN_KHZ || d > DIVIDED_MAX_KHZ)
    `CHK(err_q.loop_out_of_range, l < LOOP_MIN_KHZ || l > LOOP_MAX_KHZ)
    `CHK(err_q.core_too_fast, v > CORE_MAX_KHZ)
    $display("test end, core %0d kHz", v);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    `CHK(ccr, 16'h0000)
    `CHK(freq_q.core_khz, 32'h000186a0)
    `CHK(err_q.divided_out_of_range, 1'b1)
    $display("test end, reset");
    // Legal windows: 25 MHz divided, 525 MHz loop
    for (int i = 0; i < 8; i++) run(32'h000186a0, {5'h03, 8'h14, i[0], i[2:1]});
    run(32'h000186a0, {5'h09, 8'h1f, 1'b0, PCC_SRC_VCO});
    run(32'h000186a0, {5'h0a, 8'h1f, 1'b1, PCC_SRC_VCO_HALF});
    // Every window but divided broken on the high side, then every window on the low side
    run(32'h000249f0, {5'h05, 8'h23, 1'b1, PCC_SRC_VCO_HALF});
    run(32'h00001388, {5'h00, 8'h00, 1'b0, PCC_SRC_REF});
    srst = 1'b1;
    @(negedge clk);
    `CHK(ccr, 16'h0000)
    `CHK(freq_q.core_khz, 32'h0)
    srst = 1'b0;
    @(negedge clk);
    `CHK(freq_q.core_khz, 32'h00001388)
    $display("test end, mid-run reset");
    results();
  end
  initial begin
    #2000;
    n_errors++;
    results();
  end
endmodule
